//--- shared/lpf_pkg.sv
// constants and types shared by the line printer page formatter
package lpf_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W     = 3;
  localparam int DATA_W     = 16;
  localparam int CHAR_W     = 6;
  localparam int LEN_W      = 9;
  localparam int MARG_W     = 6;
  localparam int ADV_W      = 6;
  localparam int BASE_W     = 15;
  localparam int FEED_W     = 10;
  localparam int CCNT_W     = 8;
  localparam int LINE_CHARS = 128;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // register offsets (word index on the plain register port)
  localparam logic [ADDR_W-1:0] REG_PAGE_LEN = 3'h0;
  localparam logic [ADDR_W-1:0] REG_TOP      = 3'h1;
  localparam logic [ADDR_W-1:0] REG_BOT      = 3'h2;
  localparam logic [ADDR_W-1:0] REG_FORMAT   = 3'h3;
  localparam logic [ADDR_W-1:0] REG_BASE     = 3'h4;
  localparam logic [ADDR_W-1:0] REG_LINE     = 3'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 3'h6;
  localparam logic [ADDR_W-1:0] REG_POS      = 3'h7;

  // ==========================================================
  // fields and reset values
  localparam int LINE_NP_BIT   = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TOP_BIT  = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam logic [CHAR_W-1:0] STOP_CHAR     = 6'h3F;
  localparam logic [LEN_W-1:0]  RST_PAGE_LEN  = 9'h000;
  localparam logic [MARG_W-1:0] RST_MARGIN    = 6'h00;
  localparam logic [BASE_W-1:0] RST_BASE      = 15'h0000;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_FEED   = 2'h1,
    OP_CHAR   = 2'h2,
    OP_STRIKE = 2'h3
  } lpf_op_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_FEED   = 4'h2,
    ST_PRINT  = 4'h4,
    ST_STRIKE = 4'h8
  } lpf_state_t;

endpackage

//--- src/lpf_fifo.sv
// small synchronous fifo between character fetch and print hammers
module lpf_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;

  wire logic push = ce_i && in_valid_i && in_ready_o;
  wire logic pop  = ce_i && out_valid_o && out_ready_i;

  // ==========================================================
  // flags straight from the occupancy count
  assign in_ready_o  = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage needs no reset
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

//--- src/lpf_top.sv
// line printer page formatter: format registers, paper tracking, line print
module lpf_top
  import lpf_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  input  wire logic                       ce_i,
  input  wire logic [lpf_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [lpf_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [lpf_pkg::DATA_W-1:0] rd_data_o,
  output logic      [lpf_pkg::BASE_W-1:0] mem_addr_o,
  output logic                            mem_rd_o,
  input  wire logic [lpf_pkg::CHAR_W-1:0] mem_data_i,
  output logic                            mech_req_o,
  output lpf_pkg::lpf_op_t                mech_op_o,
  output logic      [lpf_pkg::CHAR_W-1:0] mech_char_o,
  input  wire logic                       mech_ack_i
);
  import lpf_pkg::*;

  // ==========================================================
  // state
  lpf_state_t        state;
  logic [LEN_W-1:0]  page_len;
  logic [MARG_W-1:0] top_marg;
  logic [MARG_W-1:0] bot_marg;
  logic [BASE_W-1:0] base;
  logic [LEN_W-1:0]  pos;
  logic              at_top;
  logic [FEED_W-1:0] feed_cnt;
  logic              fetch_on;
  logic              rd_pend;
  logic [CCNT_W-1:0] issued;
  logic              ack_meta;
  logic              ack_s;

  // ==========================================================
  // register port decode
  wire logic busy      = (state != ST_IDLE);
  wire logic wr_len    = ce_i && wr_i && (addr_i == REG_PAGE_LEN) && !busy;
  wire logic wr_top    = ce_i && wr_i && (addr_i == REG_TOP) && !busy;
  wire logic wr_bot    = ce_i && wr_i && (addr_i == REG_BOT) && !busy;
  wire logic wr_fmt    = ce_i && wr_i && (addr_i == REG_FORMAT) && !busy;
  wire logic wr_base   = ce_i && wr_i && (addr_i == REG_BASE) && !busy;
  wire logic line_go   = ce_i && wr_i && (addr_i == REG_LINE) && !busy;
  wire logic [ADV_W-1:0] adv = wr_data_i[ADV_W-1:0];
  wire logic             np  = wr_data_i[LINE_NP_BIT];
  wire logic fmt_zero = (page_len == '0) && (top_marg == '0) && (bot_marg == '0);
  wire logic [DATA_W-1:0] status_word = {{(DATA_W-3){1'b0}}, fmt_zero, at_top, busy};

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      REG_PAGE_LEN: rd_mux = DATA_W'(page_len);
      REG_TOP:      rd_mux = DATA_W'(top_marg);
      REG_BOT:      rd_mux = DATA_W'(bot_marg);
      REG_BASE:     rd_mux = DATA_W'(base);
      REG_STATUS:   rd_mux = status_word;
      REG_POS:      rd_mux = DATA_W'(pos);
      default:      rd_mux = '0;
    endcase
  end

  // ==========================================================
  // paper position arithmetic
  wire logic [FEED_W-1:0] pos_x    = FEED_W'(pos);
  wire logic [FEED_W-1:0] len_x    = FEED_W'(page_len);
  wire logic [FEED_W-1:0] top_x    = FEED_W'(top_marg);
  wire logic [FEED_W-1:0] bot_x    = FEED_W'(bot_marg);
  wire logic [FEED_W-1:0] adv_x    = FEED_W'(adv);
  wire logic [FEED_W-1:0] to_next  = len_x - pos_x;
  wire logic [FEED_W-1:0] to_first = to_next + top_x;
  wire logic [FEED_W-1:0] target   = pos_x + adv_x;
  wire logic [FEED_W-1:0] limit    = len_x - bot_x;
  wire logic              in_bot   = (target >= limit);

  logic [FEED_W-1:0] next_feed;
  logic [LEN_W-1:0]  next_pos;
  logic              next_top;
  logic              next_print;
  always_comb begin
    next_feed  = adv_x;
    next_pos   = LEN_W'(target);
    next_top   = 1'b0;
    next_print = 1'b1;
    if (fmt_zero) begin
      // no page model: spacing only, a next-page request moves nothing
      next_feed  = np ? '0 : adv_x;
      next_pos   = '0;
      next_print = (base != '0);
    end else if (base == '0) begin
      next_feed  = to_next;
      next_pos   = '0;
      next_top   = 1'b1;
      next_print = 1'b0;
    end else if (at_top) begin
      // paper sits on line zero here, so the margin is the whole feed
      next_feed = top_x;
      next_pos  = LEN_W'(top_marg);
    end else if (np || in_bot) begin
      next_feed = to_first;
      next_pos  = LEN_W'(top_marg);
    end
  end

  // ==========================================================
  // mechanism handshake: four phase, ack comes from the printer pins
  wire logic mech_free = !mech_req_o && !ack_s;
  wire logic mech_done = mech_req_o && ack_s;
  wire logic fifo_in_ready;
  wire logic fifo_out_valid;
  wire logic [CHAR_W-1:0] fifo_out_data;
  wire logic is_stop   = (mem_data_i == STOP_CHAR);
  wire logic push_char = rd_pend && !is_stop;
  wire logic issue_rd  = (state == ST_PRINT) && fetch_on && !rd_pend && fifo_in_ready;
  wire logic send_char = (state == ST_PRINT) && mech_free && fifo_out_valid;
  wire logic line_end  = (state == ST_PRINT) && !fetch_on && !rd_pend && !fifo_out_valid
                         && mech_free;
  wire logic last_rd   = is_stop || (issued == CCNT_W'(LINE_CHARS));

  lpf_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_char),
    .in_data_i   (mem_data_i),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (send_char)
  );

  // ==========================================================
  // synchroniser for the mechanism acknowledge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_meta <= 1'b0;
      ack_s    <= 1'b0;
    end else if (ce_i) begin
      ack_meta <= mech_ack_i;
      ack_s    <= ack_meta;
    end
  end

  // ==========================================================
  // format and register storage, refused while a line is in progress
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_len  <= RST_PAGE_LEN;
      top_marg  <= RST_MARGIN;
      bot_marg  <= RST_MARGIN;
      base      <= RST_BASE;
      rd_data_o <= '0;
    end else if (ce_i) begin
      if (wr_len) begin
        page_len <= wr_data_i[LEN_W-1:0];
      end
      if (wr_top) begin
        top_marg <= wr_data_i[MARG_W-1:0];
      end
      if (wr_bot) begin
        bot_marg <= wr_data_i[MARG_W-1:0];
      end
      if (wr_base) begin
        base <= wr_data_i[BASE_W-1:0];
      end
      rd_data_o <= rd_i ? rd_mux : '0;
    end
  end

  // ==========================================================
  // sequencer: feed, fetch and print, strike
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= ST_IDLE;
      pos         <= '0;
      at_top      <= 1'b0;
      feed_cnt    <= '0;
      fetch_on    <= 1'b0;
      rd_pend     <= 1'b0;
      issued      <= '0;
      mem_addr_o  <= '0;
      mem_rd_o    <= 1'b0;
      mech_req_o  <= 1'b0;
      mech_op_o   <= OP_NONE;
      mech_char_o <= '0;
    end else if (ce_i) begin
      mem_rd_o <= issue_rd;
      if (mech_done) begin
        mech_req_o <= 1'b0;
      end
      unique case (state)
        ST_IDLE: begin
          if (wr_fmt) begin
            // format only: no mechanism request is raised
            pos    <= '0;
            at_top <= 1'b1;
          end else if (line_go) begin
            pos      <= next_pos;
            at_top   <= next_top;
            feed_cnt <= next_feed;
            fetch_on <= next_print;
            issued   <= '0;
            state    <= ST_FEED;
          end
        end
        ST_FEED: begin
          // spacing strictly before any character goes out
          if (mech_done) begin
            feed_cnt <= feed_cnt - 1'b1;
          end else if (mech_free && feed_cnt != '0) begin
            mech_req_o <= 1'b1;
            mech_op_o  <= OP_FEED;
          end else if (mech_free) begin
            state <= fetch_on ? ST_PRINT : ST_IDLE;
          end
        end
        ST_PRINT: begin
          if (issue_rd) begin
            mem_addr_o <= base + BASE_W'(issued);
            issued     <= issued + 1'b1;
            rd_pend    <= 1'b1;
          end else if (rd_pend) begin
            rd_pend <= 1'b0;
            if (last_rd) begin
              fetch_on <= 1'b0;
            end
          end
          if (send_char) begin
            mech_req_o  <= 1'b1;
            mech_op_o   <= OP_CHAR;
            mech_char_o <= fifo_out_data;
          end else if (line_end) begin
            mech_req_o <= 1'b1;
            mech_op_o  <= OP_STRIKE;
            state      <= ST_STRIKE;
          end
        end
        ST_STRIKE: begin
          if (mech_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

//--- tb/lpf_mech_model.sv
// behavioural printer mechanism: acks requests and logs what it did
module lpf_mech_model
  import lpf_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  input  wire logic                       slow_i,
  input  wire logic                       mech_req_i,
  input  wire lpf_pkg::lpf_op_t           mech_op_i,
  input  wire logic [lpf_pkg::CHAR_W-1:0] mech_char_i,
  output logic                            mech_ack_o,
  output logic      [15:0]                n_feed_o,
  output logic      [15:0]                n_strike_o,
  output logic      [15:0]                line_len_o,
  output logic      [lpf_pkg::CHAR_W-1:0] first_char_o,
  output logic      [lpf_pkg::CHAR_W-1:0] last_char_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] cur = 16'h0000;

  initial begin
    mech_ack_o = 1'b0;
    n_feed_o   = 16'h0000;
    n_strike_o = 16'h0000;
    line_len_o = 16'h0000;
  end

  // slow mode lets the fetch fifo fill up against a stalled printer
  always begin
    @(posedge clock_i);
    if (nrst_i && mech_req_i && !mech_ack_o) begin
      if (slow_i) repeat (6) @(posedge clock_i);
      case (mech_op_i)
        OP_FEED: n_feed_o = n_feed_o + 16'h0001;
        OP_CHAR: begin
          if (cur == 16'h0000) first_char_o = mech_char_i;
          last_char_o = mech_char_i;
          cur = cur + 16'h0001;
        end
        OP_STRIKE: begin
          n_strike_o = n_strike_o + 16'h0001;
          line_len_o = cur;
          cur = 16'h0000;
        end
        default: ;
      endcase
      mech_ack_o <= 1'b1;
      while (mech_req_i) @(posedge clock_i);
      mech_ack_o <= 1'b0;
    end
  end
endmodule

//--- tb/lpf_top_monitor.sv
// port checker for the line printer page formatter
module lpf_top_monitor
  import lpf_pkg::*;
(
  input wire logic                       clock_i,
  input wire logic                       nrst_i,
  input wire logic                       ce_i,
  input wire logic [lpf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [lpf_pkg::DATA_W-1:0] wr_data_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [lpf_pkg::DATA_W-1:0] rd_data_o,
  input wire logic [lpf_pkg::BASE_W-1:0] mem_addr_o,
  input wire logic                       mem_rd_o,
  input wire logic [lpf_pkg::CHAR_W-1:0] mem_data_i,
  input wire logic                       mech_req_o,
  input wire lpf_pkg::lpf_op_t           mech_op_o,
  input wire logic [lpf_pkg::CHAR_W-1:0] mech_char_o,
  input wire logic                       mech_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // helpers: per-line fetch state, cleared by the strike request except last_addr
  logic              in_line;
  logic              stop_seen;
  logic [7:0]        n_reads;
  logic [BASE_W-1:0] last_addr;
  wire strike_req = mech_req_o && (mech_op_o == OP_STRIKE);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_line   <= 1'b0;
      stop_seen <= 1'b0;
      n_reads   <= 8'h00;
      last_addr <= 15'h0000;
    end else if (strike_req) begin
      in_line   <= 1'b0;
      stop_seen <= 1'b0;
      n_reads   <= 8'h00;
    end else begin
      if (mech_req_o && mech_op_o == OP_CHAR) in_line <= 1'b1;
      // buffer data is taken while the read pulse stands
      if (mem_rd_o && mem_data_i == STOP_CHAR) stop_seen <= 1'b1;
      if (mem_rd_o) begin
        n_reads   <= n_reads + 8'h01;
        last_addr <= mem_addr_o;
      end
    end
  end

  // ==========================================================
  // assertions
  sequence s_ack_taken;
    mech_req_o && $rose(mech_ack_i);
  endsequence

  a_read_idle_zero: assert property (ce_i && !rd_i |=> rd_data_o == 16'h0000)
    else $error("read data not zero outside read answer");
  a_req_held: assert property (mech_req_o && !mech_ack_i |=> mech_req_o)
    else $error("mechanism request dropped before acknowledge");
  a_req_stable: assert property (mech_req_o && !mech_ack_i |=>
    $stable(mech_op_o) && $stable(mech_char_o))
    else $error("mechanism op or char changed during request");
  a_req_release: assert property (s_ack_taken |=> mech_req_o ##[1:2] !mech_req_o)
    else $error("request not released two to three cycles after acknowledge");
  a_wait_ack_low: assert property (mech_ack_i && !mech_req_o |=> !mech_req_o)
    else $error("new request while acknowledge still high");
  a_char_not_stop: assert property (mech_req_o && mech_op_o == OP_CHAR |->
    mech_char_o != STOP_CHAR)
    else $error("stop character sent to hammers");
  a_no_feed_mid: assert property (mech_req_o && in_line |-> mech_op_o != OP_FEED)
    else $error("paper fed after characters of a line");
  a_stop_ends_fetch: assert property (stop_seen |-> !mem_rd_o)
    else $error("buffer read after stop character");
  a_line_max_reads: assert property (mem_rd_o |-> n_reads < 8'h80)
    else $error("more than 128 buffer reads in one line");
  a_addr_step: assert property (mem_rd_o && n_reads != 8'h00 |->
    mem_addr_o == last_addr + 15'h0001)
    else $error("buffer address did not step by one");
endmodule

//--- tb/lpf_top_tb.sv
// self-checking bench for the line printer page formatter
module lpf_top_tb;
  import lpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] addr_i = 3'h0;
  logic [DATA_W-1:0] wr_data_i = 16'h0000, rd_data_o, st;
  logic [BASE_W-1:0] mem_addr_o;
  logic [CHAR_W-1:0] mem_data, mem [0:511], c_first, c_last, mech_char_o;
  logic [CHAR_W-1:0] junk = 6'h15;
  logic mem_rd_o, mech_req_o, mech_ack_i;
  lpf_op_t mech_op_o;
  logic [15:0] n_feed, n_strike, line_len;
  int fails = 0, n_checks = 0, cycles = 0;

  always #12.5 clock_i = ~clock_i;

  lpf_top i_lpf_top (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_data_i(mem_data),
    .mech_req_o(mech_req_o), .mech_op_o(mech_op_o), .mech_char_o(mech_char_o),
    .mech_ack_i(mech_ack_i));

  lpf_mech_model i_lpf_mech_model (.clock_i(clock_i), .nrst_i(nrst_i), .slow_i(slow),
    .mech_req_i(mech_req_o), .mech_op_i(mech_op_o), .mech_char_i(mech_char_o),
    .mech_ack_o(mech_ack_i), .n_feed_o(n_feed), .n_strike_o(n_strike),
    .line_len_o(line_len), .first_char_o(c_first), .last_char_o(c_last));

  // line buffer: data while the read pulse stands, scrambled otherwise
  always @(posedge clock_i) junk <= ~junk;
  assign mem_data = mem_rd_o ? mem[mem_addr_o[8:0]] : junk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rd_data_o;
  endtask

  // pos of 16'hFFFF skips the position read
  task automatic line(input logic [15:0] base, cmd, nf, ns, pos);
    logic [15:0] f0, s0, s;
    f0 = n_feed;
    s0 = n_strike;
    s = 16'h0001;
    wr(REG_BASE, base);
    wr(REG_LINE, cmd);
    for (int k = 0; k < 3000 && s[STAT_BUSY_BIT] !== 1'b0; k++) rd(REG_STATUS, s);
    check("feeds", n_feed - f0, nf);
    check("strikes", n_strike - s0, ns);
    if (pos !== 16'hFFFF) begin
      rd(REG_POS, s);
      check("position", s, pos);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    for (int i = 0; i < 512; i++) mem[i] = STOP_CHAR;
    for (int i = 0; i < 3; i++) mem[16 + i] = 6'(i + 1);
    for (int i = 0; i < 128; i++) mem[256 + i] = 6'(i % 62 + 1);
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    wr(REG_PAGE_LEN, 16'h0014);
    wr(REG_TOP, 16'h0003);
    wr(REG_BOT, 16'h0004);
    wr(REG_FORMAT, 16'h0000);
    repeat (8) @(posedge clock_i);
    check("format feeds", n_feed, 16'h0000);
    rd(REG_STATUS, st);
    check("status", st & 16'h0007, 16'h0002);
    rd(REG_FORMAT, st);
    check("format read", st, 16'h0000);
    line(16'h0010, 16'h0005, 16'h0003, 16'h0001, 16'h0003);
    check("chars", line_len, 16'h0003);
    check("last char", 16'(c_last), 16'h0003);
    line(16'h0010, 16'h0000, 16'h0000, 16'h0001, 16'h0003);
    line(16'h0010, 16'h0005, 16'h0005, 16'h0001, 16'h0008);
    line(16'h0010, 16'h0008, 16'h000F, 16'h0001, 16'h0003);
    line(16'h0010, 16'h0040, 16'h0014, 16'h0001, 16'h0003);
    line(16'h0000, 16'h0005, 16'h0011, 16'h0000, 16'h0000);
    line(16'h0010, 16'h0007, 16'h0003, 16'h0001, 16'h0003);
    slow = 1'b1;
    line(16'h0100, 16'h0001, 16'h0001, 16'h0001, 16'h0004);
    check("long line", line_len, 16'h0080);
    check("first char", 16'(c_first), 16'h0001);
    check("end char", 16'(c_last), 16'h0004);
    slow = 1'b0;
    wr(REG_PAGE_LEN, 16'h0000);
    wr(REG_TOP, 16'h0000);
    wr(REG_BOT, 16'h0000);
    wr(REG_FORMAT, 16'h0000);
    rd(REG_STATUS, st);
    check("zero format", 16'(st[STAT_ZERO_BIT]), 16'h0001);
    // a write while the clock enable is low must leave the format alone
    @(posedge clock_i);
    ce <= 1'b0;
    wr(REG_BOT, 16'h0005);
    ce <= 1'b1;
    rd(REG_BOT, st);
    check("frozen write", st, 16'h0000);
    line(16'h0010, 16'h0002, 16'h0002, 16'h0001, 16'hFFFF);
    line(16'h0010, 16'h003F, 16'h003F, 16'h0001, 16'hFFFF);
    tally_and_finish();
  end
endmodule

bind lpf_top lpf_top_monitor i_lpf_top_monitor (.clock_i(clock_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
  .mem_data_i(mem_data_i), .mech_req_o(mech_req_o), .mech_op_o(mech_op_o),
  .mech_char_o(mech_char_o), .mech_ack_i(mech_ack_i));
